// ===== inc/bsp_defs.vh
// Purpose: Shared constants for the bank-switched memory port.
// Assumes: 32-bit APB data, byte addresses, one word per register.
// Notes: Included by every design file of the port.
`ifndef BSP_DEFS_VH
`define BSP_DEFS_VH

`define BSP_WORD_W 18
`define BSP_LANE_W 9
`define BSP_LANES 2
`define BSP_WORD_AW 12
`define BSP_BANK_W 6
`define BSP_ADDR_W 18
`define BSP_DEPTH 262144
`define BSP_APB_AW 8

`define BSP_REG_CTRL 8'h00
`define BSP_REG_STATUS 8'h04
`define BSP_REG_ADDR 8'h08
`define BSP_REG_WRCNT 8'h0C

`define BSP_CTRL_PIPE_BIT 0
`define BSP_CTRL_BLOCK_BIT 1
`define BSP_STAT_CONFLICT_BIT 0
`define BSP_STAT_SELECTED_BIT 1
`define BSP_STAT_PIPE_BIT 2

`define BSP_CTRL_RESET 2'h2
`define BSP_WRCNT_RESET 16'h0000
`define BSP_ADDR_RESET 18'h00000

`endif

// ===== rtl/bsp_addr_ctr.v
// Purpose: Address counter of one memory port, spanning bank and word.
// Assumes: Control inputs are synchronous to pclk and active low.
// Notes: Load beats repeat, repeat beats advance; otherwise the address holds.
`timescale 1ns/100ps
`include "bsp_defs.vh"

module bsp_addr_ctr (
  input wire pclk,
  input wire presetn,
  input wire load_n,
  input wire repeat_n,
  input wire advance_n,
  input wire [`BSP_ADDR_W-1:0] ext_addr,
  output reg [`BSP_ADDR_W-1:0] acc_addr_q
);

  reg [`BSP_ADDR_W-1:0] last_load_q;
  reg [`BSP_ADDR_W-1:0] acc_addr_d;

  // The counter is the access address itself, so the location reached by an
  // advance is the one accessed in the same cycle.
  always @* begin
    if (!load_n) begin
      acc_addr_d = ext_addr;
    end else if (!repeat_n) begin
      acc_addr_d = last_load_q;
    end else if (!advance_n) begin
      // Carry out of the word field steps the bank; the top wraps to zero.
      acc_addr_d = acc_addr_q + 18'h00001;
    end else begin
      acc_addr_d = acc_addr_q;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_addr_q <= `BSP_ADDR_RESET;
      last_load_q <= `BSP_ADDR_RESET;
    end else begin
      acc_addr_q <= acc_addr_d;
      if (!load_n) begin
        last_load_q <= ext_addr;
      end
    end
  end

endmodule // bsp_addr_ctr

// ===== rtl/bsp_port.v
// Purpose: One port of a bank-switched shared static memory with APB status.
// Assumes: Port pins are synchronous to pclk; the far port reports its bank.
// Notes: The output enable acts on the data drivers without the clock.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "bsp_defs.vh"

module bsp_port (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`BSP_APB_AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [`BSP_WORD_AW-1:0] word_addr,
  input wire [`BSP_BANK_W-1:0] bank_select,
  input wire address_load_strobe_n,
  input wire count_advance_n,
  input wire repeat_n,
  input wire select_low_active,
  input wire select_high_active,
  input wire upper_byte_enable_n,
  input wire lower_byte_enable_n,
  input wire read_write_n,
  input wire output_enable_n,
  input wire output_latency_select_pin,
  input wire [`BSP_WORD_W-1:0] data_in,
  output reg [`BSP_WORD_W-1:0] data_out,
  output wire [`BSP_WORD_W-1:0] data_oe,
  input wire [`BSP_BANK_W-1:0] far_bank,
  input wire far_active
);

  wire [`BSP_ADDR_W-1:0] acc_addr;
  wire [`BSP_WORD_W-1:0] rd_word;
  wire [`BSP_LANES-1:0] lane_drive;
  wire [`BSP_LANES-1:0] ben_n;
  wire selected;
  wire conflict;
  wire apb_wr;
  wire apb_setup;
  reg sel_q;
  reg wr_q;
  reg rd_q;
  reg [`BSP_LANES-1:0] ben_q;
  reg [`BSP_WORD_W-1:0] din_q;
  reg [`BSP_WORD_W-1:0] pipe_data_q;
  reg [`BSP_LANES-1:0] pipe_en_q;
  reg [`BSP_LANES-1:0] drive_q;
  reg [1:0] ctrl_q;
  reg strap_done_q;
  reg conflict_q;
  reg [15:0] wrcnt_q;
  reg [31:0] rdata_d;
  reg rerr_d;

  assign ben_n = {upper_byte_enable_n, lower_byte_enable_n};
  assign selected = !select_low_active && select_high_active;

  // Counter and access address register; inputs are taken at this edge.
  bsp_addr_ctr u_ctr (
    .pclk(pclk),
    .presetn(presetn),
    .load_n(address_load_strobe_n),
    .repeat_n(repeat_n),
    .advance_n(count_advance_n),
    .ext_addr({bank_select, word_addr}),
    .acc_addr_q(acc_addr)
  );

  // Registered port controls. A deselected cycle leaves no access pending,
  // which is the power-down state of this port alone.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ben_q <= {`BSP_LANES{1'b1}};
      din_q <= {`BSP_WORD_W{1'b0}};
    end else begin
      sel_q <= selected;
      wr_q <= selected && !read_write_n;
      rd_q <= selected && read_write_n;
      ben_q <= ben_n;
      din_q <= data_in;
    end
  end

  // A shared bank makes both accesses invalid; writes may be blocked here so
  // a controller slip does not corrupt this port's target.
  assign conflict = sel_q && far_active && (far_bank == acc_addr[`BSP_ADDR_W-1:`BSP_WORD_AW]);

  // One storage array per nine-bit half; the bank is the top six address bits.
  genvar l;
  generate
    for (l = 0; l < `BSP_LANES; l = l + 1) begin : g_lane
      reg [`BSP_LANE_W-1:0] lane_mem [0:`BSP_DEPTH-1];
      always @(posedge pclk) begin
        if (wr_q && !ben_q[l] && !(conflict && ctrl_q[`BSP_CTRL_BLOCK_BIT])) begin
          lane_mem[acc_addr] <= din_q[l*`BSP_LANE_W +: `BSP_LANE_W];
        end
      end
      assign rd_word[l*`BSP_LANE_W +: `BSP_LANE_W] = lane_mem[acc_addr];
      assign lane_drive[l] = rd_q && !ben_q[l];
      // Drivers follow the registered lane state, gated by the enable pin.
      assign data_oe[l*`BSP_LANE_W +: `BSP_LANE_W] =
        {`BSP_LANE_W{drive_q[l] && !output_enable_n}};
    end
  endgenerate

  // Output path. Flow-through loads the output register straight from the
  // array; pipelined mode passes through one more stage. Deselect cuts the
  // drivers at the next edge in both modes, byte enables follow their own access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_data_q <= {`BSP_WORD_W{1'b0}};
      pipe_en_q <= {`BSP_LANES{1'b0}};
      data_out <= {`BSP_WORD_W{1'b0}};
      drive_q <= {`BSP_LANES{1'b0}};
    end else begin
      pipe_data_q <= rd_word;
      pipe_en_q <= lane_drive;
      if (ctrl_q[`BSP_CTRL_PIPE_BIT]) begin
        data_out <= pipe_data_q;
        drive_q <= pipe_en_q & {`BSP_LANES{selected}};
      end else begin
        data_out <= rd_word;
        drive_q <= lane_drive & {`BSP_LANES{selected}};
      end
    end
  end

  // APB slave with zero wait states: pready rises for the access phase only.
  assign apb_setup = psel && !penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite;

  always @* begin
    rdata_d = 32'h00000000;
    rerr_d = 1'b0;
    if (paddr == `BSP_REG_CTRL) begin
      rdata_d[1:0] = ctrl_q;
    end else if (paddr == `BSP_REG_STATUS) begin
      rdata_d[`BSP_STAT_CONFLICT_BIT] = conflict_q;
      rdata_d[`BSP_STAT_SELECTED_BIT] = sel_q;
      rdata_d[`BSP_STAT_PIPE_BIT] = ctrl_q[`BSP_CTRL_PIPE_BIT];
    end else if (paddr == `BSP_REG_ADDR) begin
      rdata_d[`BSP_ADDR_W-1:0] = acc_addr;
    end else if (paddr == `BSP_REG_WRCNT) begin
      rdata_d[15:0] = wrcnt_q;
    end else begin
      rerr_d = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        pslverr <= rerr_d;
        prdata <= pwrite ? 32'h00000000 : rdata_d;
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
      end
    end
  end

  // Control register. The latency pin is a strap caught one cycle after
  // reset release; software may override it afterwards.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `BSP_CTRL_RESET;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q) begin
        ctrl_q[`BSP_CTRL_PIPE_BIT] <= output_latency_select_pin;
      end else if (apb_wr && paddr == `BSP_REG_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end
    end
  end

  // Sticky conflict flag, write one to clear; a new conflict wins the clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conflict_q <= 1'b0;
    end else if (conflict) begin
      conflict_q <= 1'b1;
    end else if (apb_wr && paddr == `BSP_REG_STATUS && pwdata[`BSP_STAT_CONFLICT_BIT]) begin
      conflict_q <= 1'b0;
    end
  end

  // Count of port write cycles, blocked ones too, wrapping; an APB write to WRCNT clears it,
  // and a write landing in the same cycle is counted from one.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrcnt_q <= `BSP_WRCNT_RESET;
    end else if (apb_wr && paddr == `BSP_REG_WRCNT) begin
      wrcnt_q <= {15'h0000, wr_q};
    end else if (wr_q) begin
      wrcnt_q <= wrcnt_q + 16'h0001;
    end
  end

endmodule // bsp_port

// ===== tb/bsp_host.sv
// Purpose: Host controller model driving one memory port.
// Assumes: Control word is {load_n, advance_n, repeat_n, read_write_n}.
// Notes: On reads the data lines toggle, so stale write data never looks valid.
`timescale 1ns/100ps
module bsp_host (
  input wire pclk,
  output reg [17:0] addr,
  output reg [3:0] ctl,
  output reg [17:0] din
);
  initial begin
    addr = 18'h00000;
    ctl = 4'hF;
    din = 18'h00000;
  end
  // Reads and writes follow back to back, with no idle turnaround cycle
  // that would leave a location needing a rewrite.
  task cyc(input [3:0] c, input [17:0] a, input [17:0] d);
    @(posedge pclk);
    ctl <= c;
    addr <= a;
    din <= c[0] ? ~din : d;
  endtask
endmodule // bsp_host

// ===== tb/bsp_port_assertions.sv
// Purpose: Protocol checks on the pins of one memory port.
// Assumes: Single pclk domain, bound to bsp_port.
// Notes: Watches what the port drives and the pins that control it.
`timescale 1ns/100ps
module bsp_port_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire address_load_strobe_n,
  input wire count_advance_n,
  input wire repeat_n,
  input wire select_low_active,
  input wire select_high_active,
  input wire upper_byte_enable_n,
  input wire lower_byte_enable_n,
  input wire read_write_n,
  input wire output_enable_n,
  input wire [17:0] data_out,
  input wire [17:0] data_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire sel = !select_low_active && select_high_active;
  wire keep = address_load_strobe_n && count_advance_n && repeat_n && read_write_n;
  sequence hold_rd;
    (keep && sel && !upper_byte_enable_n && !lower_byte_enable_n)[*4];
  endsequence
  a_oe_async: assert property (output_enable_n |-> data_oe == 0)
    else $error("driving with output enable off");
  a_desel_float: assert property (!sel |=> data_oe == 0)
    else $error("driving after deselect");
  a_two_selected: assert property (data_oe != 0 |-> $past(sel) && $past(sel, 2))
    else $error("driving too soon after select");
  a_data_hold: assert property (hold_rd |-> $stable(data_out))
    else $error("read data moved while held");
  a_setup_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
endmodule // bsp_port_chk

bind bsp_port bsp_port_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .address_load_strobe_n(address_load_strobe_n), .count_advance_n(count_advance_n),
  .repeat_n(repeat_n), .select_low_active(select_low_active),
  .select_high_active(select_high_active), .upper_byte_enable_n(upper_byte_enable_n),
  .lower_byte_enable_n(lower_byte_enable_n), .read_write_n(read_write_n),
  .output_enable_n(output_enable_n), .data_out(data_out), .data_oe(data_oe));

// ===== tb/bsp_port_bench.sv
// Purpose: Directed bench for one bank-switched memory port.
// Assumes: Strap held flow-through; pipelined mode is set through CTRL.
// Notes: Far port is modelled by far_b and far_act only.
`timescale 1ns/100ps
`include "bsp_defs.vh"
module bsp_port_bench;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg sel_lo = 1, sel_hi = 1, ube_n = 0, lbe_n = 0, oe_n = 0, far_act = 0;
  // The far port never writes, so no cross-port clock offset arises.
  reg [5:0] far_b = 6'h00;
  reg [17:0] last = 18'h00000;
  integer err_count = 0, n_checks = 0, cyc_n = 0;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [17:0] a, d, q, qoe;
  wire [3:0] c;
  wire [17:0] m = {{9{!ube_n}}, {9{!lbe_n}}};
  always #2.5 pclk = ~pclk;
  bsp_host host_u (.pclk(pclk), .addr(a), .ctl(c), .din(d));
  bsp_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .word_addr(a[11:0]), .bank_select(a[17:12]),
    .address_load_strobe_n(c[3]), .count_advance_n(c[2]), .repeat_n(c[1]),
    .select_low_active(sel_lo), .select_high_active(sel_hi), .upper_byte_enable_n(ube_n),
    .lower_byte_enable_n(lbe_n), .read_write_n(c[0]), .output_enable_n(oe_n),
    .output_latency_select_pin(1'b0), .data_in(d), .data_out(q), .data_oe(qoe),
    .far_bank(far_b), .far_active(far_act));
  task chk(input string nm, input [31:0] s, input [31:0] e);
    n_checks = n_checks + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task apb(input w, input [7:0] ad, input [31:0] wd, input [31:0] e, input ee);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    chk("pslverr", {31'h0, pslverr}, {31'h0, ee});
    if (!w) chk("prdata", prdata, e);
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input [17:0] ad, input [17:0] e, input [1:0] lat);
    host_u.cyc(4'h7, ad, 18'h0);
    host_u.cyc(4'hF, ad, 18'h0);
    @(posedge pclk);
    if (lat == 2) begin
      #1 chk("early data", q, last);
      @(posedge pclk);
    end
    #1 chk("read data", q & m, e & m);
    chk("drive", qoe, m & {18{!oe_n}});
    repeat (3) @(posedge pclk);
    #1 chk("held data", q & m, e & m);
    last = e;
  endtask
  always @(posedge pclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      err_count = err_count + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    apb(0, `BSP_REG_CTRL, 0, 32'h2, 0);
    apb(0, 8'h10, 0, 32'h0, 1);
    host_u.cyc(4'h6, 18'h00FFF, 18'h2AAAA);
    sel_lo <= 0;
    host_u.cyc(4'hA, 18'h0, 18'h15555);
    host_u.cyc(4'hF, 18'h0, 18'h0);
    apb(0, `BSP_REG_ADDR, 0, 32'h01000, 0);
    host_u.cyc(4'h6, 18'h3FFFF, 18'h12345);
    host_u.cyc(4'hA, 18'h0, 18'h3C3C3);
    host_u.cyc(4'hF, 18'h0, 18'h0);
    apb(0, `BSP_REG_ADDR, 0, 32'h0, 0);
    rd(18'h00FFF, 18'h2AAAA, 1);
    rd(18'h01000, 18'h15555, 1);
    host_u.cyc(4'h7, 18'h3FFFF, 18'h0);
    host_u.cyc(4'hB, 18'h0, 18'h0);
    host_u.cyc(4'hB, 18'h0, 18'h0);
    host_u.cyc(4'hD, 18'h0, 18'h0);
    host_u.cyc(4'hF, 18'h0, 18'h0);
    apb(0, `BSP_REG_ADDR, 0, 32'h3FFFF, 0);
    chk("repeat data", q, 18'h12345);
    ube_n <= 1;
    host_u.cyc(4'h6, 18'h01000, 18'h0);
    host_u.cyc(4'hF, 18'h01000, 18'h0);
    ube_n <= 0;
    rd(18'h01000, 18'h15400, 1);
    @(posedge pclk);
    lbe_n <= 1;
    rd(18'h00FFF, 18'h2AAAA, 1);
    @(posedge pclk);
    lbe_n <= 0;
    oe_n <= 1;
    #1 chk("oe off", qoe, 18'h0);
    @(posedge pclk);
    oe_n <= 0;
    sel_hi <= 0;
    @(posedge pclk);
    #1 chk("deselect", qoe, 18'h0);
    @(posedge pclk);
    sel_hi <= 1;
    rd(18'h00000, 18'h3C3C3, 1);
    apb(1, `BSP_REG_CTRL, 32'h3, 0, 0);
    apb(0, `BSP_REG_STATUS, 0, 32'h6, 0);
    rd(18'h00000, 18'h3C3C3, 2);
    // Deliberate same-bank access: this port writes while the far port is active.
    host_u.cyc(4'h6, 18'h00FFF, 18'h00001);
    far_act <= 1;
    host_u.cyc(4'h7, 18'h00000, 18'h0);
    host_u.cyc(4'hF, 18'h00000, 18'h0);
    far_act <= 0;
    apb(0, `BSP_REG_STATUS, 0, 32'h7, 0);
    apb(1, `BSP_REG_STATUS, 32'h1, 0, 0);
    apb(0, `BSP_REG_STATUS, 0, 32'h6, 0);
    rd(18'h00FFF, 18'h2AAAA, 2);
    report_and_stop;
  end
endmodule // bsp_port_bench
